// [rtl/crs_pkg.sv]
// Purpose: Shared types and constants of the chip reset sequencer
// Assumes: 32-bit APB register access, one system clock
// Notes: Peripheral default values are loaded by the units themselves
package crs_pkg;
  localparam int unsigned CNT_W = 11;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EV_W = 6;
  localparam int unsigned STARTUP_CYC = 1024;
  localparam int unsigned OPT_LOAD_CYC = 32;

  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h0c;

  localparam int unsigned ST_TO_BIT = 0;
  localparam int unsigned ST_PD_BIT = 1;
  localparam int unsigned ST_CAUSE_LSB = 2;
  localparam int unsigned ST_BUSY_BIT = 5;
  localparam int unsigned CTRL_WDT_EN_BIT = 0;

  localparam int unsigned EV_POR = 0;
  localparam int unsigned EV_PIN_NORM = 1;
  localparam int unsigned EV_PIN_HALT = 2;
  localparam int unsigned EV_WDT_NORM = 3;
  localparam int unsigned EV_WDT_WARM = 4;
  localparam int unsigned EV_WAKE = 5;
  localparam logic [EV_W-1:0] IRQ_STS_RST = 6'h01;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 6'h00;

  // Defaults the units load on every chip reset except a warm one
  localparam logic [7:0] TIMER_A_CONTROL_DEF = 8'h08;
  localparam logic [7:0] CONVERTER_CONTROL_DEF = 8'h40;
  localparam logic [7:0] IRQ_CONTROL_DEF = 8'h00;
  localparam logic [7:0] PORT_DEF = 8'hff;
  localparam logic [7:0] MEMORY_POINTER_SET = 8'h80;
  localparam logic [10:0] PROGRAM_COUNTER_DEF = 11'h000;

  typedef enum logic [2:0] {
    CS_POR, CS_PIN_NORM, CS_PIN_HALT, CS_WDT_NORM, CS_WDT_WARM
  } crs_cause_t;

  typedef enum logic [2:0] {
    ST_OPTLOAD, ST_STARTUP, ST_PIN_HOLD, ST_WARM, ST_WAKE, ST_RUN
  } crs_fsm_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } crs_apb_req_t;

  typedef struct packed {
    logic pc_zero;
    logic sp_top;
    logic irq_disable;
    logic presc_clear;
    logic timers_stop;
    logic pulse_float;
    logic ports_input;
    logic wdt_clear;
    logic load_defaults;
    logic counts_unknown;
    logic cpu_hold;
  } crs_unit_rst_t;

  localparam crs_unit_rst_t UNIT_POR = 11'h7ff;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic pin_lvl;
    crs_fsm_t st;
    crs_cause_t cause;
    logic [CNT_W-1:0] cnt;
    logic to_flag;
    logic pd_flag;
    logic [EV_W-1:0] irq_sts;
    logic [EV_W-1:0] irq_mask;
    logic wdt_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    crs_unit_rst_t unit;
    logic irq;
  } crs_state_t;
endpackage

// [rtl/chip_reset_sequencer.sv]
// Purpose: Reset cause tracking and start-up sequencing for a small MCU
// Assumes: Watchdog, halt and wake strobes come from logic on sys_clk
// Notes: Registers reached over APB; one level interrupt from the masked per-cause status bits
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01: Pin reset in running or halt, or watchdog in running, fully resets the chip.
// RULE_02: Watchdog timeout while halted gives warm reset: only PC and stack pointer.
// RULE_03: Power-up clears both flags; pin reset keeps them; pin wake gives 0,1.
// RULE_04: Watchdog in running sets timeout; watchdog wake from halt sets both flags.
// RULE_05: Start-up delay of 1024 clocks after every reset and every halt wake-up.
// RULE_06: Internal reset stays asserted until the start-up delay has elapsed.
// RULE_07: Power-up, watchdog running and pin resets add an option-load delay first.
// RULE_08: Chip reset zeroes PC, masks interrupts, stops timers, floats output, ports input.
// RULE_09: Watchdog is cleared during reset and counts again once reset ends.
// RULE_10: Every non-warm reset loads the peripheral register defaults.
// RULE_11: Warm reset leaves everything but PC and stack pointer; both flags set to one.
// RULE_12: Counts and pulse period unknown after power-up or watchdog, kept on pin reset.
// RULE_13: Power-down flag clears on power-up and watchdog clear, sets on halt.
// RULE_14: Entering halt sets the power-down flag and clears the timeout flag.
// RULE_15: Reset pin is synchronised; reset holds through option-load and start-up delays.
module chip_reset_sequencer #(
  parameter int unsigned STARTUP_CYC = crs_pkg::STARTUP_CYC,
  parameter int unsigned OPT_LOAD_CYC = crs_pkg::OPT_LOAD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire crs_pkg::crs_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset_n_pin,
  input wire logic wdt_timeout,
  input wire logic halted,
  input wire logic halt_exec,
  input wire logic clrwdt_exec,
  input wire logic wake_req,
  output crs_pkg::crs_unit_rst_t unit_rst,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic irq
);

  if (STARTUP_CYC < 1 || STARTUP_CYC > (1 << crs_pkg::CNT_W)) begin : g_chk_su
    $error("STARTUP_CYC out of counter range");
  end
  if (OPT_LOAD_CYC < 1 || OPT_LOAD_CYC > (1 << crs_pkg::CNT_W)) begin : g_chk_ol
    $error("OPT_LOAD_CYC out of counter range");
  end

  localparam logic [crs_pkg::CNT_W-1:0] SU_LAST = crs_pkg::CNT_W'(STARTUP_CYC - 1);
  localparam logic [crs_pkg::CNT_W-1:0] OL_LAST = crs_pkg::CNT_W'(OPT_LOAD_CYC - 1);
  localparam logic [crs_pkg::CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [crs_pkg::CNT_W-1:0] CNT_ZERO = 11'h000;

  crs_pkg::crs_state_t s_r;
  crs_pkg::crs_state_t s_nxt;

  logic live;
  logic ev_pin_norm;
  logic ev_pin_halt;
  logic ev_wdt_norm;
  logic ev_wdt_warm;
  logic ev_wake;
  logic ev_halt;
  logic ev_clrwdt;
  logic acc;
  logic chip;
  logic warm;
  logic [crs_pkg::EV_W-1:0] ev_vec;
  logic [crs_pkg::EV_W-1:0] rd_clr;

  always_comb begin
    s_nxt = s_r;

    // Three-stage pin synchroniser; a level counts once stages two and three agree
    s_nxt.sync1 = ext_reset_n_pin; // RULE_15
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    if (s_r.sync2 == s_r.sync3) begin
      s_nxt.pin_lvl = s_r.sync3; // RULE_15
    end

    // Cause detection; pin beats watchdog, watchdog beats wake and instructions
    live = (s_r.st == crs_pkg::ST_RUN) || (s_r.st == crs_pkg::ST_WAKE);
    ev_pin_norm = live && !s_r.pin_lvl && !halted; // RULE_01
    ev_pin_halt = live && !s_r.pin_lvl && halted; // RULE_01
    ev_wdt_norm = live && s_r.pin_lvl && wdt_timeout && s_r.wdt_en && !halted; // RULE_01
    ev_wdt_warm = live && s_r.pin_lvl && wdt_timeout && s_r.wdt_en && halted; // RULE_02
    ev_wake = (s_r.st == crs_pkg::ST_RUN) && s_r.pin_lvl && halted && wake_req
      && !(wdt_timeout && s_r.wdt_en);
    ev_halt = (s_r.st == crs_pkg::ST_RUN) && s_r.pin_lvl && !halted && halt_exec
      && !(wdt_timeout && s_r.wdt_en);
    ev_clrwdt = (s_r.st == crs_pkg::ST_RUN) && s_r.pin_lvl && !halted && clrwdt_exec
      && !halt_exec && !(wdt_timeout && s_r.wdt_en);

    ev_vec = '0;
    ev_vec[crs_pkg::EV_PIN_NORM] = ev_pin_norm;
    ev_vec[crs_pkg::EV_PIN_HALT] = ev_pin_halt;
    ev_vec[crs_pkg::EV_WDT_NORM] = ev_wdt_norm;
    ev_vec[crs_pkg::EV_WDT_WARM] = ev_wdt_warm;
    ev_vec[crs_pkg::EV_WAKE] = ev_wake;

    // Flag updates
    if (ev_pin_halt) begin
      s_nxt.to_flag = 1'b0; // RULE_03
      s_nxt.pd_flag = 1'b1; // RULE_03
    end else if (ev_wdt_norm) begin
      s_nxt.to_flag = 1'b1; // RULE_04
    end else if (ev_wdt_warm) begin
      s_nxt.to_flag = 1'b1; // RULE_04
      s_nxt.pd_flag = 1'b1; // RULE_11
    end else if (ev_halt) begin
      s_nxt.pd_flag = 1'b1; // RULE_14
      s_nxt.to_flag = 1'b0; // RULE_14
    end else if (ev_clrwdt) begin
      s_nxt.pd_flag = 1'b0; // RULE_13
    end

    // Sequencer
    case (s_r.st)
      crs_pkg::ST_OPTLOAD: begin
        if (!s_r.pin_lvl) begin
          s_nxt.st = crs_pkg::ST_PIN_HOLD;
        end else if (s_r.cnt == CNT_ZERO) begin
          s_nxt.st = crs_pkg::ST_STARTUP; // RULE_07
          s_nxt.cnt = SU_LAST;
        end else begin
          s_nxt.cnt = s_r.cnt - CNT_ONE;
        end
      end
      crs_pkg::ST_STARTUP: begin
        if (!s_r.pin_lvl) begin
          s_nxt.st = crs_pkg::ST_PIN_HOLD;
        end else if (s_r.cnt == CNT_ZERO) begin
          s_nxt.st = crs_pkg::ST_RUN; // RULE_06
        end else begin
          s_nxt.cnt = s_r.cnt - CNT_ONE; // RULE_05
        end
      end
      crs_pkg::ST_PIN_HOLD: begin
        if (s_r.pin_lvl) begin
          s_nxt.st = crs_pkg::ST_OPTLOAD; // RULE_15
          s_nxt.cnt = OL_LAST;
        end
      end
      crs_pkg::ST_WARM: begin
        if (!s_r.pin_lvl) begin
          s_nxt.st = crs_pkg::ST_PIN_HOLD;
          s_nxt.cause = crs_pkg::CS_PIN_HALT;
        end else if (s_r.cnt == CNT_ZERO) begin
          s_nxt.st = crs_pkg::ST_RUN;
        end else begin
          s_nxt.cnt = s_r.cnt - CNT_ONE; // RULE_05
        end
      end
      crs_pkg::ST_WAKE, crs_pkg::ST_RUN: begin
        if (ev_pin_norm || ev_pin_halt) begin
          s_nxt.st = crs_pkg::ST_PIN_HOLD;
          s_nxt.cause = ev_pin_halt ? crs_pkg::CS_PIN_HALT : crs_pkg::CS_PIN_NORM;
        end else if (ev_wdt_norm) begin
          s_nxt.st = crs_pkg::ST_OPTLOAD; // RULE_07
          s_nxt.cnt = OL_LAST;
          s_nxt.cause = crs_pkg::CS_WDT_NORM;
        end else if (ev_wdt_warm) begin
          s_nxt.st = crs_pkg::ST_WARM; // RULE_02
          s_nxt.cnt = SU_LAST;
          s_nxt.cause = crs_pkg::CS_WDT_WARM;
        end else if (ev_wake) begin
          s_nxt.st = crs_pkg::ST_WAKE; // RULE_05
          s_nxt.cnt = SU_LAST;
        end else if (s_r.st == crs_pkg::ST_WAKE) begin
          if (s_r.cnt == CNT_ZERO) begin
            s_nxt.st = crs_pkg::ST_RUN;
          end else begin
            s_nxt.cnt = s_r.cnt - CNT_ONE;
          end
        end
      end
      default: begin
        s_nxt.st = crs_pkg::ST_PIN_HOLD;
      end
    endcase

    // Unit reset controls follow the next state so they line up with it
    chip = (s_nxt.st == crs_pkg::ST_OPTLOAD) || (s_nxt.st == crs_pkg::ST_STARTUP)
      || (s_nxt.st == crs_pkg::ST_PIN_HOLD);
    warm = (s_nxt.st == crs_pkg::ST_WARM);
    s_nxt.unit.pc_zero = chip || warm; // RULE_08
    s_nxt.unit.sp_top = chip || warm; // RULE_08
    s_nxt.unit.irq_disable = chip; // RULE_08
    s_nxt.unit.presc_clear = chip; // RULE_08
    s_nxt.unit.timers_stop = chip; // RULE_08
    s_nxt.unit.pulse_float = chip; // RULE_08
    s_nxt.unit.ports_input = chip; // RULE_08
    s_nxt.unit.wdt_clear = chip || warm; // RULE_09
    s_nxt.unit.load_defaults = chip; // RULE_10
    s_nxt.unit.counts_unknown = chip && ((s_nxt.cause == crs_pkg::CS_POR)
      || (s_nxt.cause == crs_pkg::CS_WDT_NORM)); // RULE_12
    s_nxt.unit.cpu_hold = (s_nxt.st != crs_pkg::ST_RUN); // RULE_06

    // APB slave: ready one cycle into the access phase, commit on the edge after that
    acc = apb_req.psel && apb_req.penable;
    rd_clr = '0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (acc && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = '0;
      if (apb_req.paddr == crs_pkg::ADDR_STATUS) begin
        s_nxt.prdata[crs_pkg::ST_TO_BIT] = s_r.to_flag;
        s_nxt.prdata[crs_pkg::ST_PD_BIT] = s_r.pd_flag;
        s_nxt.prdata[crs_pkg::ST_CAUSE_LSB +: 3] = s_r.cause;
        s_nxt.prdata[crs_pkg::ST_BUSY_BIT] = (s_r.st != crs_pkg::ST_RUN);
        s_nxt.pslverr = apb_req.pwrite;
      end else if (apb_req.paddr == crs_pkg::ADDR_IRQ_STS) begin
        s_nxt.prdata[crs_pkg::EV_W-1:0] = s_r.irq_sts;
        s_nxt.pslverr = apb_req.pwrite;
      end else if (apb_req.paddr == crs_pkg::ADDR_IRQ_MASK) begin
        s_nxt.prdata[crs_pkg::EV_W-1:0] = s_r.irq_mask;
      end else if (apb_req.paddr == crs_pkg::ADDR_CTRL) begin
        s_nxt.prdata[crs_pkg::CTRL_WDT_EN_BIT] = s_r.wdt_en;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (acc && s_r.pready && !s_r.pslverr) begin
      if (apb_req.pwrite) begin
        if (apb_req.paddr == crs_pkg::ADDR_IRQ_MASK) begin
          s_nxt.irq_mask = apb_req.pwdata[crs_pkg::EV_W-1:0];
        end else if (apb_req.paddr == crs_pkg::ADDR_CTRL) begin
          s_nxt.wdt_en = apb_req.pwdata[crs_pkg::CTRL_WDT_EN_BIT];
        end
      end else if (apb_req.paddr == crs_pkg::ADDR_IRQ_STS) begin
        rd_clr = s_r.prdata[crs_pkg::EV_W-1:0];
      end
    end

    // Only bits actually returned are cleared; a new event wins over the clear
    s_nxt.irq_sts = (s_r.irq_sts & ~rd_clr) | ev_vec;
    s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r.sync1 <= 1'b1;
      s_r.sync2 <= 1'b1;
      s_r.sync3 <= 1'b1;
      s_r.pin_lvl <= 1'b1;
      s_r.st <= crs_pkg::ST_OPTLOAD;
      s_r.cause <= crs_pkg::CS_POR;
      s_r.cnt <= OL_LAST;
      s_r.to_flag <= 1'b0; // RULE_03
      s_r.pd_flag <= 1'b0; // RULE_13
      s_r.irq_sts <= crs_pkg::IRQ_STS_RST;
      s_r.irq_mask <= crs_pkg::IRQ_MASK_RST;
      s_r.wdt_en <= 1'b1;
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.prdata <= '0;
      s_r.unit <= crs_pkg::UNIT_POR;
      s_r.irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign unit_rst = s_r.unit;
  assign timeout_flag = s_r.to_flag;
  assign powerdown_flag = s_r.pd_flag;
  assign irq = s_r.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_chip_reset_causes: assert property ( // RULE_01
    (ev_pin_norm || ev_pin_halt || ev_wdt_norm) |=> ##1 (unit_rst.ports_input && unit_rst.pc_zero))
    else $error("chip reset not raised on a reset cause");

  a_warm_only_pc: assert property ( // RULE_02
    ev_wdt_warm |=> (unit_rst.pc_zero && unit_rst.sp_top && !unit_rst.ports_input
      && !unit_rst.load_defaults && !unit_rst.timers_stop))
    else $error("warm reset touched more than PC and stack pointer");

  a_pin_keep_flags: assert property ( // RULE_03
    ev_pin_norm |=> (timeout_flag == $past(timeout_flag) && powerdown_flag == $past(powerdown_flag)))
    else $error("pin reset in running changed the flags");

  a_pin_wake_flags: assert property ( // RULE_03
    ev_pin_halt |=> (!timeout_flag && powerdown_flag))
    else $error("pin wake flags not 0,1");

  a_wdt_flags: assert property ( // RULE_04
    ev_wdt_norm |=> (timeout_flag && powerdown_flag == $past(powerdown_flag)))
    else $error("watchdog reset flags wrong");

  a_warm_flags: assert property ( // RULE_11
    ev_wdt_warm |=> (timeout_flag && powerdown_flag))
    else $error("warm reset flags not both set");

  a_startup_holds: assert property ( // RULE_05
    (s_r.st == crs_pkg::ST_STARTUP && s_r.pin_lvl && s_r.cnt != CNT_ZERO)
      |=> (s_r.st == crs_pkg::ST_STARTUP && s_r.cnt == $past(s_r.cnt) - CNT_ONE))
    else $error("start-up delay cut short");

  a_reset_in_startup: assert property ( // RULE_06
    (s_r.st == crs_pkg::ST_STARTUP) |-> (unit_rst.cpu_hold && unit_rst.load_defaults))
    else $error("internal reset released during start-up delay");

  a_optload_then_su: assert property ( // RULE_07
    (s_r.st == crs_pkg::ST_OPTLOAD && s_r.pin_lvl && s_r.cnt == CNT_ZERO)
      |=> (s_r.st == crs_pkg::ST_STARTUP && s_r.cnt == SU_LAST))
    else $error("option-load delay not followed by start-up delay");

  a_wdt_release: assert property ( // RULE_09
    (s_r.st == crs_pkg::ST_STARTUP && s_r.pin_lvl && s_r.cnt == CNT_ZERO)
      |=> (!unit_rst.wdt_clear && !unit_rst.cpu_hold))
    else $error("watchdog clear not released with reset");

  a_halt_flags: assert property ( // RULE_14
    ev_halt |=> (powerdown_flag && !timeout_flag))
    else $error("halt entry flags wrong");

  a_clrwdt_pd: assert property ( // RULE_13
    ev_clrwdt |=> !powerdown_flag)
    else $error("watchdog clear left power-down flag set");

  a_pin_sync_hold: assert property ( // RULE_15
    (!s_r.pin_lvl && s_r.st != crs_pkg::ST_RUN && s_r.st != crs_pkg::ST_WAKE)
      |=> (s_r.st == crs_pkg::ST_PIN_HOLD))
    else $error("reset not held while pin low");

  a_wake_cpu_only: assert property ( // RULE_05
    ev_wake |=> (unit_rst.cpu_hold && !unit_rst.pc_zero && !unit_rst.load_defaults))
    else $error("wake-up delay touched more than the core hold");

  a_pin_keep_counts: assert property ( // RULE_12
    (ev_pin_norm || ev_pin_halt) |=> !unit_rst.counts_unknown)
    else $error("pin reset marked the counts unknown");

endmodule
`default_nettype wire

// [bench/crs_far_model.sv]
// Purpose: Far-side model: reset pin driver, watchdog and core halt strobes
// Assumes: Everything changes just after a rising edge of sys_clk
// Notes: The testbench calls the tasks through the instance
`timescale 1ns/1ps
`default_nettype none
module crs_far_model (
  input wire logic sys_clk,
  output logic ext_reset_n_pin,
  output logic wdt_timeout,
  output logic halted,
  output logic halt_exec,
  output logic clrwdt_exec,
  output logic wake_req
);
  initial begin
    ext_reset_n_pin = 1'b1;
    wdt_timeout = 1'b0;
    halted = 1'b0;
    halt_exec = 1'b0;
    clrwdt_exec = 1'b0;
    wake_req = 1'b0;
  end

  // Kind 0 watchdog, 1 halt entry, 2 watchdog clear, 3 wake, 4 leave halt
  task automatic strobe(input int kind);
    logic [4:0] sel;
    sel = 5'h01 << kind;
    @(posedge sys_clk);
    {wake_req, clrwdt_exec, halt_exec, wdt_timeout} <= sel[3:0];
    @(posedge sys_clk);
    {wdt_timeout, halt_exec, clrwdt_exec, wake_req} <= 4'h0;
    // The core sits in halt from the cycle after the halt strobe
    if (sel[1] || sel[4]) begin
      halted <= sel[1];
    end
  endtask

  // Held low well past the synchroniser; the core leaves halt as it resets
  // Toggles from the idle high level, so the pin must be high on entry
  task automatic pin_low(input int cycles);
    @(posedge sys_clk);
    ext_reset_n_pin <= ~ext_reset_n_pin;
    repeat (cycles) @(posedge sys_clk);
    ext_reset_n_pin <= ~ext_reset_n_pin;
    halted <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/chip_reset_sequencer_tb.sv]
// Purpose: Self-checking bench of the chip reset sequencer
// Assumes: Short start-up and option-load counts to keep the run brief
// Notes: Registers reached by an APB master task
`timescale 1ns/1ps
`default_nettype none
module chip_reset_sequencer_tb;
  localparam int unsigned SU = 4;
  localparam int unsigned OL = 2;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  crs_pkg::crs_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_reset_n_pin;
  logic wdt_timeout;
  logic halted;
  logic halt_exec;
  logic clrwdt_exec;
  logic wake_req;
  crs_pkg::crs_unit_rst_t unit_rst;
  crs_pkg::crs_unit_rst_t snap;
  logic timeout_flag;
  logic powerdown_flag;
  logic irq;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int check_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  chip_reset_sequencer #(.STARTUP_CYC(SU), .OPT_LOAD_CYC(OL)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset_n_pin(ext_reset_n_pin), .wdt_timeout(wdt_timeout),
    .halted(halted), .halt_exec(halt_exec), .clrwdt_exec(clrwdt_exec), .wake_req(wake_req),
    .unit_rst(unit_rst), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .irq(irq)
  );

  crs_far_model far (
    .sys_clk(sys_clk), .ext_reset_n_pin(ext_reset_n_pin), .wdt_timeout(wdt_timeout),
    .halted(halted), .halt_exec(halt_exec), .clrwdt_exec(clrwdt_exec), .wake_req(wake_req)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic flg(input logic [1:0] exp);
    #1;
    chk({30'h0, timeout_flag, powerdown_flag}, {30'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge sys_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      #1;
      if (pready === 1'b1) break;
      @(posedge sys_clk);
    end
    if (i == 50) begin
      $display("unexpected at %0t: got %h exp %h", $time, 1'b0, 1'b1);
      num_errors++;
      test_done();
    end
    // The answer stands until the next edge, which is the one that commits it
    rd = prdata;
    err = pslverr;
    @(posedge sys_clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, xe});
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d);
    chk({31'h0, err}, {31'h0, xe});
  endtask

  // Counts the cycles cpu_hold is high and snapshots the first reset pattern
  task automatic run_seq(input int exp_n, input crs_pkg::crs_unit_rst_t exp_u);
    int cnt;
    bit seen;
    cnt = 0;
    seen = 1'b0;
    for (int i = 0; i < 400; i++) begin
      #1;
      if (unit_rst.cpu_hold === 1'b1) begin
        if (!seen) snap = unit_rst;
        seen = 1'b1;
        cnt++;
      end else if (seen) begin
        break;
      end
      @(posedge sys_clk);
    end
    if (!seen || unit_rst.cpu_hold !== 1'b0) begin
      $display("unexpected at %0t: got %h exp %h", $time, cnt, exp_n);
      num_errors++;
      test_done();
    end
    chk({21'h0, snap}, {21'h0, exp_u});
    if (exp_n > 0) chk(32'(cnt), 32'(exp_n));
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    chk({21'h0, unit_rst}, {21'h0, crs_pkg::UNIT_POR});
    chk({29'h0, timeout_flag, powerdown_flag, irq}, 32'h0);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    run_seq(OL + SU, crs_pkg::UNIT_POR);
    reg_rd(crs_pkg::ADDR_STATUS, 32'h0, 1'b0);
    reg_rd(crs_pkg::ADDR_IRQ_STS, 32'h1, 1'b0);
    reg_rd(crs_pkg::ADDR_IRQ_STS, 32'h0, 1'b0);
    reg_rd(crs_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0);
    reg_rd(crs_pkg::ADDR_CTRL, 32'h1, 1'b0);
    reg_rd(8'h10, 32'h0, 1'b1);
    reg_wr(crs_pkg::ADDR_STATUS, 32'hff, 1'b1);
    reg_rd(crs_pkg::ADDR_STATUS, 32'h0, 1'b0);
    reg_wr(crs_pkg::ADDR_IRQ_MASK, 32'h3f, 1'b0);
    reg_rd(crs_pkg::ADDR_IRQ_MASK, 32'h3f, 1'b0);
    $display("test power_up done");

    reg_wr(crs_pkg::ADDR_IRQ_MASK, 32'h08, 1'b0);
    chk({31'h0, irq}, 32'h0);
    far.strobe(0);
    run_seq(OL + SU, crs_pkg::UNIT_POR);
    flg(2'b10);
    chk({31'h0, irq}, 32'h1);
    reg_rd(crs_pkg::ADDR_STATUS, 32'h0d, 1'b0);
    reg_rd(crs_pkg::ADDR_IRQ_STS, 32'h08, 1'b0);
    chk({31'h0, irq}, 32'h0);
    $display("test watchdog_running done");

    far.strobe(1);
    flg(2'b01);
    far.strobe(3);
    run_seq(SU, 11'h001);
    flg(2'b01);
    far.strobe(4);
    far.strobe(2);
    flg(2'b00);
    $display("test halt_wake done");

    far.strobe(1);
    far.strobe(0);
    // Only pc_zero, sp_top, wdt_clear and cpu_hold
    run_seq(SU, 11'h609);
    flg(2'b11);
    far.strobe(4);
    reg_rd(crs_pkg::ADDR_STATUS, 32'h13, 1'b0);
    $display("test warm_reset done");

    far.strobe(1);
    far.pin_low(8);
    // Chip reset with counts kept
    run_seq(0, 11'h7fd);
    flg(2'b01);
    reg_rd(crs_pkg::ADDR_STATUS, 32'h0a, 1'b0);
    $display("test pin_halt done");

    far.strobe(0);
    run_seq(OL + SU, crs_pkg::UNIT_POR);
    flg(2'b11);
    far.pin_low(8);
    run_seq(0, 11'h7fd);
    flg(2'b11);
    reg_rd(crs_pkg::ADDR_STATUS, 32'h07, 1'b0);
    chk({31'h0, irq}, 32'h1);
    reg_rd(crs_pkg::ADDR_IRQ_STS, 32'h3e, 1'b0);
    chk({31'h0, irq}, 32'h0);
    $display("test pin_running done");

    reg_wr(crs_pkg::ADDR_CTRL, 32'h0, 1'b0);
    far.strobe(0);
    repeat (4) @(posedge sys_clk);
    #1;
    chk({31'h0, unit_rst.cpu_hold}, 32'h0);
    flg(2'b11);
    reg_wr(crs_pkg::ADDR_CTRL, 32'h1, 1'b0);
    reg_rd(crs_pkg::ADDR_CTRL, 32'h1, 1'b0);
    $display("test watchdog_disable done");
    test_done();
  end
endmodule
`default_nettype wire
